// file: inc/ncap_if.sv
// links between register bank, error logger and attribute path
`timescale 1ns/1ns
`default_nettype none
interface ncap_if;
   logic [3:0] ev;
   logic [3:0] rep_on;
   logic [3:0] clr;
   logic [3:0] seen;
   logic [3:0] msg;
   logic order_relax;
   modport regs (output rep_on, output clr, output order_relax, input seen, input msg);
   modport err (input ev, input rep_on, input clr, output seen, output msg);
   modport attr (input order_relax);
   modport src (output ev);
endinterface
`default_nettype wire

// file: inc/ncap_pkg.sv
// constants for the endpoint capability register bank
package ncap_pkg;
   // configuration byte offsets
   localparam logic [11:0] OFS_DEV_CAP = 12'h044;
   localparam logic [11:0] OFS_DEV_CTL = 12'h048;
   localparam logic [11:0] OFS_DEV_STS = 12'h04a;
   localparam logic [11:0] OFS_LNK_CAP = 12'h04c;
   localparam logic [11:0] OFS_LNK_CTL = 12'h050;
   localparam logic [11:0] OFS_LNK_STS = 12'h052;
   localparam logic [11:0] OFS_MSI_CAP = 12'h064;
   // device capabilities tail
   localparam int DCAP_STANDBY_ACC = 6;
   localparam int DCAP_SLEEP_ACC = 9;
   localparam int DCAP_ATTN_BTN = 12;
   localparam logic [2:0] DCAP_ACC_VAL = 3'h7;
   localparam logic [2:0] DCAP_IND_RST = 3'h0;
   // device control
   localparam int DCTL_REPORT = 0;
   localparam int DCTL_ORDER_RELAX = 4;
   localparam int DCTL_PAYLOAD = 5;
   localparam int DCTL_WIDE_TAG = 8;
   localparam int DCTL_SNOOP_SKIP = 11;
   localparam int DCTL_RDREQ = 12;
   localparam logic [3:0] DCTL_REPORT_RST = 4'h0;
   localparam logic DCTL_ORDER_RELAX_RST = 1'b1;
   localparam logic [2:0] DCTL_PAYLOAD_RST = 3'h0;
   localparam logic [2:0] DCTL_RDREQ_RST = 3'h2;
   localparam logic [2:0] PAYLOAD_CODE_MAX = 3'h4;
   // device status
   localparam int DSTS_SEEN = 0;
   localparam logic [3:0] DSTS_SEEN_RST = 4'h0;
   // link capabilities
   localparam int LCAP_RATE = 0;
   localparam int LCAP_LANES = 4;
   localparam int LCAP_PWR = 10;
   localparam int LCAP_STANDBY = 12;
   localparam int LCAP_SLEEP = 15;
   localparam int LCAP_PORT = 24;
   localparam logic [3:0] LINK_RATE_VAL = 4'h1;
   localparam logic [5:0] LINK_LANES_VAL = 6'h08;
   localparam logic [1:0] LCAP_PWR_VAL = 2'h1;
   localparam logic [2:0] LCAP_EXIT_VAL = 3'h0;
   localparam logic [7:0] LCAP_PORT_VAL = 8'h00;
   // link control and status
   localparam int LCTL_PM = 0;
   localparam int LCTL_REFCLK = 6;
   localparam int LCTL_LONG_SYNC = 7;
   localparam logic [1:0] LCTL_PM_RST = 2'h0;
   localparam int LSTS_RATE = 0;
   localparam int LSTS_LANES = 4;
   // message interrupt header
   localparam logic [7:0] MSI_CAP_IDENT = 8'h05;
   localparam logic [7:0] MSI_NEXT_LINK = 8'h74;
   // own requests limited to 128 bytes, in dwords
   localparam logic [9:0] OWN_MAX_DW = 10'h020;
   localparam logic [11:0] PAYLOAD_MIN_BYTES = 12'h080;

   function automatic logic [11:0] payload_bytes(input logic [2:0] code);
      if (code > PAYLOAD_CODE_MAX) begin
         return PAYLOAD_MIN_BYTES;
      end
      return PAYLOAD_MIN_BYTES << code;
   endfunction
endpackage

// file: logic/ncap_attr.sv
// attribute handling for bridged and own transactions
`timescale 1ns/1ns
`default_nettype none
module ncap_attr #(
   parameter int TAG_W = 8,
   parameter int LEN_W = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // control from register bank
   ncap_if.attr b,
   // bridged transaction in
   input wire logic fwd_in_valid,
   input wire logic fwd_in_from_opp,
   input wire logic fwd_in_relaxed,
   input wire logic fwd_in_no_snoop,
   input wire logic [TAG_W-1:0] fwd_in_tag,
   input wire logic [LEN_W-1:0] fwd_in_len,
   // bridged transaction out
   output logic fwd_out_valid,
   output logic fwd_out_relaxed,
   output logic fwd_out_no_snoop,
   output logic [TAG_W-1:0] fwd_out_tag,
   output logic [LEN_W-1:0] fwd_out_len,
   // own transaction request and issue
   input wire logic own_in_valid,
   input wire logic [LEN_W-1:0] own_in_len,
   output logic own_out_valid,
   output logic own_out_no_snoop,
   output logic [TAG_W-1:0] own_out_tag,
   output logic [LEN_W-1:0] own_out_len
);
   import ncap_pkg::*;
   if (LEN_W < 6 || LEN_W > 10 || TAG_W < 5) begin : g_width_chk
      $error("ncap_attr: unsupported width");
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fwd_out_valid <= 1'b0;
         fwd_out_relaxed <= 1'b0;
         fwd_out_no_snoop <= 1'b0;
         fwd_out_tag <= '0;
         fwd_out_len <= '0;
      end else begin
         fwd_out_valid <= fwd_in_valid;
         fwd_out_relaxed <= fwd_in_relaxed & (b.order_relax | ~fwd_in_from_opp);
         fwd_out_no_snoop <= fwd_in_no_snoop;
         fwd_out_tag <= fwd_in_tag;
         fwd_out_len <= fwd_in_len;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         own_out_valid <= 1'b0;
         own_out_len <= '0;
      end else begin
         own_out_valid <= own_in_valid;
         if (own_in_len > LEN_W'(OWN_MAX_DW)) begin
            own_out_len <= LEN_W'(OWN_MAX_DW);
         end else begin
            own_out_len <= own_in_len;
         end
      end
   end

   assign own_out_no_snoop = 1'b0;
   assign own_out_tag = '0;
endmodule // ncap_attr
`default_nettype wire

// file: logic/ncap_err.sv
// sticky error status and gated error messages
`timescale 1ns/1ns
`default_nettype none
module ncap_err (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // link to register bank
   ncap_if.err e
);
   import ncap_pkg::*;
   logic [3:0] seen_q;
   logic [3:0] msg_q;

   ////////////////////////////////////////////////////////////////////////////
   // set wins over clear, logged whatever the enable
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         seen_q <= DSTS_SEEN_RST;
      end else begin
         seen_q <= (seen_q & ~e.clr) | e.ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         msg_q <= 4'h0;
      end else begin
         msg_q <= e.ev & e.rep_on;
      end
   end

   assign e.seen = seen_q;
   assign e.msg = msg_q;
endmodule // ncap_err
`default_nettype wire

// file: logic/ncap_regs.sv
// endpoint capability register bank, top level
`timescale 1ns/1ns
`default_nettype none
module ncap_regs #(
   parameter int TAG_W = 8,
   parameter int LEN_W = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   // serial eeprom preload of indicator bits
   input wire logic eeprom_load,
   input wire logic [2:0] eeprom_dcap_ind,
   // error events
   input wire logic err_minor,
   input wire logic err_nonfatal,
   input wire logic err_fatal,
   input wire logic err_unsupp_req,
   // error messages
   output logic [3:0] err_msg,
   // control views
   output logic [11:0] payload_limit_bytes,
   output logic [1:0] link_pm_ctl,
   // bridged transaction in
   input wire logic fwd_in_valid,
   input wire logic fwd_in_from_opp,
   input wire logic fwd_in_relaxed,
   input wire logic fwd_in_no_snoop,
   input wire logic [TAG_W-1:0] fwd_in_tag,
   input wire logic [LEN_W-1:0] fwd_in_len,
   // bridged transaction out
   output logic fwd_out_valid,
   output logic fwd_out_relaxed,
   output logic fwd_out_no_snoop,
   output logic [TAG_W-1:0] fwd_out_tag,
   output logic [LEN_W-1:0] fwd_out_len,
   // own transactions
   input wire logic own_in_valid,
   input wire logic [LEN_W-1:0] own_in_len,
   output logic own_out_valid,
   output logic own_out_no_snoop,
   output logic [TAG_W-1:0] own_out_tag,
   output logic [LEN_W-1:0] own_out_len
);
   import ncap_pkg::*;

   if (TAG_W != 8) begin : g_tag_chk
      $error("ncap_regs: tag width must be 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   ncap_if cx ();
   logic [3:0] rep_on_q;
   logic order_relax_q;
   logic [2:0] payload_code_q;
   logic wide_tag_q;
   logic snoop_skip_q;
   logic [2:0] rdreq_q;
   logic [1:0] pm_ctl_q;
   logic refclk_q;
   logic long_sync_q;
   logic [2:0] dcap_ind_q;
   logic [11:0] payload_bytes_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic [31:0] dev_cap_w;
   logic [15:0] dev_ctl_w;
   logic [15:0] dev_sts_w;
   logic [31:0] lnk_cap_w;
   logic [15:0] lnk_ctl_w;
   logic [15:0] lnk_sts_w;
   logic [31:0] msi_w;
   logic [31:0] rd_mux;
   logic wr_dev;
   logic wr_lnk;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      return a[11:2] == ofs[11:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // write decode
   always_comb begin
      wr_dev = 1'b0;
      wr_lnk = 1'b0;
      if (cfg_wr && hit(cfg_addr, OFS_DEV_CTL)) begin
         wr_dev = 1'b1;
      end else if (cfg_wr && hit(cfg_addr, OFS_LNK_CTL)) begin
         wr_lnk = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // device control, low byte
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rep_on_q <= DCTL_REPORT_RST;
         order_relax_q <= DCTL_ORDER_RELAX_RST;
         payload_code_q <= DCTL_PAYLOAD_RST;
      end else if (wr_dev && cfg_be[0]) begin
         rep_on_q <= cfg_wdata[DCTL_REPORT+:4];
         order_relax_q <= cfg_wdata[DCTL_ORDER_RELAX];
         payload_code_q <= cfg_wdata[DCTL_PAYLOAD+:3];
      end
   end

   // device control, high byte; storage only
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wide_tag_q <= 1'b0;
         snoop_skip_q <= 1'b0;
         rdreq_q <= DCTL_RDREQ_RST;
      end else if (wr_dev && cfg_be[1]) begin
         wide_tag_q <= cfg_wdata[DCTL_WIDE_TAG];
         snoop_skip_q <= cfg_wdata[DCTL_SNOOP_SKIP];
         rdreq_q <= cfg_wdata[DCTL_RDREQ+:3];
      end
   end

   // status clear strobe, byte two of the control dword
   always_comb begin
      cx.clr = 4'h0;
      if (wr_dev && cfg_be[2]) begin
         cx.clr = cfg_wdata[16+DSTS_SEEN+:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link control
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pm_ctl_q <= LCTL_PM_RST;
         refclk_q <= 1'b0;
         long_sync_q <= 1'b0;
      end else if (wr_lnk && cfg_be[0]) begin
         pm_ctl_q <= cfg_wdata[LCTL_PM+:2];
         refclk_q <= cfg_wdata[LCTL_REFCLK];
         long_sync_q <= cfg_wdata[LCTL_LONG_SYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indicator presence bits, preset from eeprom
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dcap_ind_q <= DCAP_IND_RST;
      end else if (eeprom_load) begin
         dcap_ind_q <= eeprom_dcap_ind;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // payload limit decode
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         payload_bytes_q <= payload_bytes(DCTL_PAYLOAD_RST);
      end else begin
         payload_bytes_q <= payload_bytes(payload_code_q);
      end
   end

   assign payload_limit_bytes = payload_bytes_q;
   assign link_pm_ctl = pm_ctl_q;

   ////////////////////////////////////////////////////////////////////////////
   // read images
   always_comb begin
      dev_cap_w = 32'h0000_0000;
      dev_cap_w[DCAP_STANDBY_ACC+:3] = DCAP_ACC_VAL;
      dev_cap_w[DCAP_SLEEP_ACC+:3] = DCAP_ACC_VAL;
      dev_cap_w[DCAP_ATTN_BTN+:3] = dcap_ind_q;
   end

   always_comb begin
      dev_ctl_w = 16'h0000;
      dev_ctl_w[DCTL_REPORT+:4] = rep_on_q;
      dev_ctl_w[DCTL_ORDER_RELAX] = order_relax_q;
      dev_ctl_w[DCTL_PAYLOAD+:3] = payload_code_q;
      dev_ctl_w[DCTL_WIDE_TAG] = wide_tag_q;
      dev_ctl_w[DCTL_SNOOP_SKIP] = snoop_skip_q;
      dev_ctl_w[DCTL_RDREQ+:3] = rdreq_q;
   end

   always_comb begin
      dev_sts_w = 16'h0000;
      dev_sts_w[DSTS_SEEN+:4] = cx.seen;
   end

   always_comb begin
      lnk_cap_w = 32'h0000_0000;
      lnk_cap_w[LCAP_RATE+:4] = LINK_RATE_VAL;
      lnk_cap_w[LCAP_LANES+:6] = LINK_LANES_VAL;
      lnk_cap_w[LCAP_PWR+:2] = LCAP_PWR_VAL;
      lnk_cap_w[LCAP_STANDBY+:3] = LCAP_EXIT_VAL;
      lnk_cap_w[LCAP_SLEEP+:3] = LCAP_EXIT_VAL;
      lnk_cap_w[LCAP_PORT+:8] = LCAP_PORT_VAL;
   end

   always_comb begin
      lnk_ctl_w = 16'h0000;
      lnk_ctl_w[LCTL_PM+:2] = pm_ctl_q;
      lnk_ctl_w[LCTL_REFCLK] = refclk_q;
      lnk_ctl_w[LCTL_LONG_SYNC] = long_sync_q;
   end

   always_comb begin
      lnk_sts_w = 16'h0000;
      lnk_sts_w[LSTS_RATE+:4] = LINK_RATE_VAL;
      lnk_sts_w[LSTS_LANES+:6] = LINK_LANES_VAL;
   end

   always_comb begin
      msi_w = 32'h0000_0000;
      msi_w[7:0] = MSI_CAP_IDENT;
      msi_w[15:8] = MSI_NEXT_LINK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read decode, unmapped reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(cfg_addr, OFS_DEV_CAP)) begin
         rd_mux = dev_cap_w;
      end else if (hit(cfg_addr, OFS_DEV_CTL)) begin
         rd_mux = {dev_sts_w, dev_ctl_w};
      end else if (hit(cfg_addr, OFS_LNK_CAP)) begin
         rd_mux = lnk_cap_w;
      end else if (hit(cfg_addr, OFS_LNK_CTL)) begin
         rd_mux = {lnk_sts_w, lnk_ctl_w};
      end else if (hit(cfg_addr, OFS_MSI_CAP)) begin
         rd_mux = msi_w;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (cfg_rd) begin
         rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cfg_rd | cfg_wr;
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_ack = ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // error logging
   assign cx.ev = {err_unsupp_req, err_fatal, err_nonfatal, err_minor};
   assign cx.rep_on = rep_on_q;
   assign cx.order_relax = order_relax_q;
   assign err_msg = cx.msg;

   ncap_err u_err (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .e (cx.err)
   );

   ////////////////////////////////////////////////////////////////////////////
   // transaction attributes
   ncap_attr #(
      .TAG_W (TAG_W),
      .LEN_W (LEN_W)
   ) u_attr (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .b (cx.attr),
      .fwd_in_valid (fwd_in_valid),
      .fwd_in_from_opp (fwd_in_from_opp),
      .fwd_in_relaxed (fwd_in_relaxed),
      .fwd_in_no_snoop (fwd_in_no_snoop),
      .fwd_in_tag (fwd_in_tag),
      .fwd_in_len (fwd_in_len),
      .fwd_out_valid (fwd_out_valid),
      .fwd_out_relaxed (fwd_out_relaxed),
      .fwd_out_no_snoop (fwd_out_no_snoop),
      .fwd_out_tag (fwd_out_tag),
      .fwd_out_len (fwd_out_len),
      .own_in_valid (own_in_valid),
      .own_in_len (own_in_len),
      .own_out_valid (own_out_valid),
      .own_out_no_snoop (own_out_no_snoop),
      .own_out_tag (own_out_tag),
      .own_out_len (own_out_len)
   );
endmodule // ncap_regs
`default_nettype wire

// file: testbench/ncap_checker.sv
// concurrent checks on the capability register bank ports
`timescale 1ns/1ns
`default_nettype none
module ncap_checker #(
   parameter int TAG_W = 8,
   parameter int LEN_W = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   // errors
   input wire logic err_unsupp_req,
   input wire logic [3:0] err_msg,
   // transactions
   input wire logic fwd_in_valid,
   input wire logic fwd_in_from_opp,
   input wire logic fwd_in_relaxed,
   input wire logic fwd_in_no_snoop,
   input wire logic [TAG_W-1:0] fwd_in_tag,
   input wire logic fwd_out_relaxed,
   input wire logic fwd_out_no_snoop,
   input wire logic [TAG_W-1:0] fwd_out_tag,
   input wire logic own_in_valid,
   input wire logic own_out_no_snoop,
   input wire logic [TAG_W-1:0] own_out_tag,
   input wire logic [LEN_W-1:0] own_out_len
);
   import ncap_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire logic rd_ctl = cfg_rd && cfg_addr[11:2] == OFS_DEV_CTL[11:2];
   wire logic rd_lcap = cfg_rd && cfg_addr[11:2] == OFS_LNK_CAP[11:2];
   wire logic rd_lctl = cfg_rd && cfg_addr[11:2] == OFS_LNK_CTL[11:2];
   wire logic rd_msi = cfg_rd && cfg_addr[11:2] == OFS_MSI_CAP[11:2];
   ////////////////////////////////////////////////////////////////////////////
   property p_ack; (cfg_wr || cfg_rd) |=> cfg_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing after request");
   property p_lcap; rd_lcap |=> cfg_rdata == 32'h00000481; endproperty
   a_lcap: assert property (p_lcap) else $error("link caps wrong");
   property p_lctl; rd_lctl |=> cfg_rdata[31:16] == 16'h0081 && cfg_rdata[5:2] == 4'h0; endproperty
   a_lctl: assert property (p_lctl) else $error("link ctl or sts wrong");
   property p_msi; rd_msi |=> cfg_rdata[15:0] == 16'h7405; endproperty
   a_msi: assert property (p_msi) else $error("message header wrong");
   property p_ctl; rd_ctl |=> cfg_rdata[15] == 1'b0 && cfg_rdata[10:9] == 2'h0
      && cfg_rdata[31:20] == 12'h000; endproperty
   a_ctl: assert property (p_ctl) else $error("fixed control bits set");
   property p_pass; fwd_in_valid |=> fwd_out_tag == $past(fwd_in_tag)
      && fwd_out_no_snoop == $past(fwd_in_no_snoop); endproperty
   a_pass: assert property (p_pass) else $error("tag or no snoop altered");
   property p_strict; fwd_in_valid && !fwd_in_relaxed |=> !fwd_out_relaxed; endproperty
   a_strict: assert property (p_strict) else $error("relaxed bit invented");
   property p_same; fwd_in_valid && !fwd_in_from_opp |=> fwd_out_relaxed == $past(fwd_in_relaxed);
   endproperty
   a_same: assert property (p_same) else $error("outbound order altered");
   property p_own; own_out_tag == '0 && !own_out_no_snoop; endproperty
   a_own: assert property (p_own) else $error("own tag or no snoop set");
   property p_cap; own_in_valid |=> own_out_len <= 32; endproperty
   a_cap: assert property (p_cap) else $error("own length over limit");
   property p_msg; err_msg[3] |-> $past(err_unsupp_req); endproperty
   a_msg: assert property (p_msg) else $error("message without event");
   c_lcap: cover property (rd_lcap);
   c_msg: cover property (err_msg != 4'h0);
   c_strict: cover property (fwd_in_valid && fwd_in_from_opp && fwd_in_relaxed ##1 !fwd_out_relaxed);
endmodule // ncap_checker
bind ncap_regs ncap_checker #(.TAG_W(TAG_W), .LEN_W(LEN_W)) u_chk (.clk_sys, .reset_n,
   .cfg_wr, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_ack, .err_unsupp_req, .err_msg, .fwd_in_valid,
   .fwd_in_from_opp, .fwd_in_relaxed, .fwd_in_no_snoop, .fwd_in_tag, .fwd_out_relaxed,
   .fwd_out_no_snoop, .fwd_out_tag, .own_in_valid, .own_out_no_snoop, .own_out_tag, .own_out_len);
`default_nettype wire

// file: testbench/ncap_host.sv
// host-side configuration requester model
`timescale 1ns/1ns
`default_nettype none
module ncap_host (
   // clock
   input wire logic clk_sys,
   // configuration access
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [11:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 12'h000;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
   end
   // one request pulse, answer taken with the ack
   task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      @(negedge clk_sys);
      cfg_wr = w;
      cfg_rd = !w;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      // released lanes never keep the old value
      cfg_wdata = ~d;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (cfg_ack === 1'b1) begin
            ok = 1'b1;
            q = cfg_rdata;
         end else @(negedge clk_sys);
      end
   endtask
endmodule // ncap_host
`default_nettype wire

// file: testbench/ncap_regs_tb.sv
// self-checking bench for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module ncap_regs_tb;
   import ncap_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, eeprom_load = 1'b0;
   logic [2:0] eeprom_dcap_ind = 3'h0;
   logic err_minor = 1'b0, err_nonfatal = 1'b0, err_fatal = 1'b0, err_unsupp_req = 1'b0;
   logic fwd_in_valid = 1'b0, fwd_in_from_opp = 1'b0, fwd_in_relaxed = 1'b0;
   logic fwd_in_no_snoop = 1'b0, own_in_valid = 1'b0;
   logic [7:0] fwd_in_tag = 8'h00;
   logic [9:0] fwd_in_len = 10'h000, own_in_len = 10'h000;
   wire logic cfg_wr, cfg_rd, cfg_ack, fwd_out_valid, fwd_out_relaxed, fwd_out_no_snoop;
   wire logic own_out_valid, own_out_no_snoop;
   wire logic [11:0] cfg_addr, payload_limit_bytes;
   wire logic [3:0] cfg_be, err_msg;
   wire logic [31:0] cfg_wdata, cfg_rdata;
   wire logic [1:0] link_pm_ctl;
   wire logic [7:0] fwd_out_tag, own_out_tag;
   wire logic [9:0] fwd_out_len, own_out_len;
   int fails = 0;
   int n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   ncap_regs uut (.clk_sys, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata, .cfg_ack, .eeprom_load, .eeprom_dcap_ind, .err_minor, .err_nonfatal,
      .err_fatal, .err_unsupp_req, .err_msg, .payload_limit_bytes, .link_pm_ctl, .fwd_in_valid,
      .fwd_in_from_opp, .fwd_in_relaxed, .fwd_in_no_snoop, .fwd_in_tag, .fwd_in_len,
      .fwd_out_valid, .fwd_out_relaxed, .fwd_out_no_snoop, .fwd_out_tag, .fwd_out_len,
      .own_in_valid, .own_in_len, .own_out_valid, .own_out_no_snoop, .own_out_tag, .own_out_len);
   ncap_host host (.clk_sys, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
      .cfg_ack);
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
      logic ok;
      host.xfer(w, a, be, d, q, ok);
      if (ok !== 1'b1) begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, be, d, q);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 4'h0, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic fwd(input logic opp, input logic rel, input logic er);
      @(negedge clk_sys);
      fwd_in_valid = 1'b1;
      fwd_in_from_opp = opp;
      fwd_in_relaxed = rel;
      fwd_in_no_snoop = !rel;
      fwd_in_tag = {7'h52, opp};
      fwd_in_len = 10'h3ff;
      @(negedge clk_sys);
      fwd_in_valid = 1'b0;
      chk("fwd_vld_rel", {30'h0, 1'b1, er}, {30'h0, fwd_out_valid, fwd_out_relaxed});
      chk("fwd_tag", {24'h0, 7'h52, opp}, {24'h0, fwd_out_tag});
      chk("fwd_ns_len", {21'h0, !rel, 10'h3ff}, {21'h0, fwd_out_no_snoop, fwd_out_len});
      fwd_in_tag = ~fwd_in_tag;
   endtask
   task automatic pulse(input logic [3:0] ev);
      @(negedge clk_sys);
      {err_unsupp_req, err_fatal, err_nonfatal, err_minor} = ev;
      @(negedge clk_sys);
      {err_unsupp_req, err_fatal, err_nonfatal, err_minor} = 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rchk("dev_ctl", 12'h048, 32'h00002010);
      rchk("dev_cap", 12'h044, 32'h00000fc0);
      rchk("lnk_cap", 12'h04c, 32'h00000481);
      rchk("lnk_ctl", 12'h050, 32'h00810000);
      rchk("msi_hdr", 12'h064, 32'h00007405);
      rchk("unmapped", 12'h0c0, 32'h0);
      chk("payload", 32'h80, {20'h0, payload_limit_bytes});
   endtask
   task automatic t_ctl;
      wr(12'h048, 4'h3, 32'hffffffff);
      rchk("dev_ctl_ones", 12'h048, 32'h000079ff);
      wr(12'h050, 4'hf, 32'hffffffff);
      rchk("lnk_ctl_ones", 12'h050, 32'h008100c3);
      chk("pm_ctl", 32'h3, {30'h0, link_pm_ctl});
      wr(12'h04c, 4'hf, 32'h0);
      rchk("lnk_cap_ro", 12'h04c, 32'h00000481);
      wr(12'h064, 4'hf, 32'h0);
      rchk("msi_ro", 12'h064, 32'h00007405);
   endtask
   task automatic t_payload;
      for (int c = 0; c < 8; c++) begin
         wr(12'h048, 4'h1, 32'(c) << 5);
         repeat (2) @(negedge clk_sys);
         chk("payload", (c > 4) ? 32'h80 : 32'h80 << c, {20'h0, payload_limit_bytes});
      end
   endtask
   task automatic t_order;
      fwd(1'b1, 1'b1, 1'b0);
      fwd(1'b0, 1'b1, 1'b1);
      wr(12'h048, 4'h1, 32'h10);
      fwd(1'b1, 1'b1, 1'b1);
      fwd(1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_own;
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_sys);
         own_in_valid = 1'b1;
         own_in_len = (i == 0) ? 10'h3ff : (i == 1) ? 10'h021 : 10'h011;
         @(negedge clk_sys);
         own_in_valid = 1'b0;
         own_in_len = ~own_in_len;
         chk("own_len", (i == 2) ? 32'h411 : 32'h420, {21'h0, own_out_valid, own_out_len});
         chk("own_tag_ns", 32'h0, {23'h0, own_out_no_snoop, own_out_tag});
      end
   endtask
   task automatic t_err;
      pulse(4'hf);
      chk("msg_off", 32'h0, {28'h0, err_msg});
      rchk("sts_set", 12'h048, 32'h000f7910);
      wr(12'h048, 4'h4, 32'h00010000);
      rchk("sts_clr", 12'h048, 32'h000e7910);
      wr(12'h048, 4'h4, 32'h0);
      rchk("sts_zero_wr", 12'h048, 32'h000e7910);
      wr(12'h048, 4'h1, 32'h1f);
      pulse(4'h4);
      chk("msg_fatal", 32'h4, {28'h0, err_msg});
      fork
         wr(12'h048, 4'h4, 32'h00010000);
         pulse(4'h1);
      join
      rchk("sts_race", 12'h048, 32'h000f791f);
   endtask
   task automatic t_eeprom;
      @(negedge clk_sys);
      eeprom_load = 1'b1;
      eeprom_dcap_ind = 3'h5;
      @(negedge clk_sys);
      eeprom_load = 1'b0;
      eeprom_dcap_ind = 3'h2;
      rchk("dev_cap_load", 12'h044, 32'h00005fc0);
   endtask
   initial begin
      repeat (16) @(negedge clk_sys);
      reset_n = 1'b1;
      t_reset();
      t_ctl();
      t_payload();
      t_order();
      t_own();
      t_err();
      t_eeprom();
      @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      rchk("dev_ctl_rst2", 12'h048, 32'h00002010);
      rchk("dev_cap_rst2", 12'h044, 32'h00000fc0);
      wrap_up();
   end
endmodule // ncap_regs_tb
`default_nettype wire
